// ==== sarpr_buf.sv ====
// Shared constants and types, plus the two-entry result buffer
`timescale 1ns/1ps
package sarpr_pkg;
  localparam int SARPR_CLK_NS = 20;
  localparam int SARPR_CONV_NS = 650;
  // Longest time rounds down to whole cycles
  localparam int SARPR_CONV_CYC = SARPR_CONV_NS / SARPR_CLK_NS;
  localparam int SARPR_BITS = 16;
  localparam int SARPR_BYTE_W = 8;
  localparam int SARPR_STEP_CYC = SARPR_CONV_CYC / SARPR_BITS;
  localparam int SARPR_STEP_W = $clog2(SARPR_STEP_CYC + 1);
  localparam int SARPR_IDX_W = $clog2(SARPR_BITS);
  localparam int SARPR_TRIM_W = 2;
  localparam logic [SARPR_TRIM_W-1:0] SARPR_TRIM_CONV = 2'h3;
  localparam int SARPR_BUF_DEPTH = 2;
  localparam logic [SARPR_BITS-1:0] SARPR_SAR_INIT = 16'h8000;
  localparam logic [SARPR_BYTE_W-1:0] SARPR_FILL_BYTE = 8'hFF;
  localparam logic [SARPR_IDX_W-1:0] SARPR_IDX_MSB = 4'hF;
  localparam logic [SARPR_IDX_W-1:0] SARPR_IDX_LSB = 4'h0;
  localparam logic [SARPR_STEP_W-1:0] SARPR_STEP_LAST =
    SARPR_STEP_W'(SARPR_STEP_CYC - 1);

  typedef struct packed {
    logic trimmed;
    logic [SARPR_BITS-1:0] code;
  } sarpr_word_s;

  localparam int SARPR_WORD_W = $bits(sarpr_word_s);
  localparam sarpr_word_s SARPR_WORD_ZERO = '0;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_HOLD} sarpr_state_e;
endpackage

module sarpr_buf
  import sarpr_pkg::*;
#(
  parameter int WIDTH = SARPR_WORD_W,
  parameter int DEPTH = SARPR_BUF_DEPTH
)
(
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_flush, // Drop all entries
  input wire logic i_in_valid, // Word offered
  output logic o_in_ready, // Room for a word
  input wire logic [WIDTH-1:0] i_in_data, // Word in
  output logic o_out_valid, // Word available
  input wire logic i_out_ready, // Drain accepts
  output logic [WIDTH-1:0] o_out_data // Oldest word
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic push;
  logic pop;

  assign o_in_ready = (count_r != FULL_CNT);
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_r[wr_ptr_r] <= i_in_data;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else if (i_flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// ==== sarpr_top.sv ====
// Conversion control and parallel readout of the SAR converter
// Notes on behaviour
// - Start falling edge moves sample to hold
// - Busy rises after start, falls at end
// - Conversion finishes within 650 ns; here busy stays high 35 cycles (700 ns) or more after start
// - Timing from internal divider, no host clock
// - Sampling restarts on busy or select falling
// - Data pins driven only when select, read low
// - Result coded two's complement around midscale
// - Byte-select low gives whole 16-bit word
// - Byte-select high: low byte up, ones below
// - Toggled or held read both work
// - First three conversions after power-up invalid
// - Start during conversion with select triggers reset
// - Select falling during conversion triggers reset
// - Internal reset zeroes latches, drops busy
`timescale 1ns/1ps
module sarpr_top
  import sarpr_pkg::*;
(
  input wire logic i_clock, // 50 MHz clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_convert_start_n, // Conversion start, active low
  input wire logic i_cs_n, // Chip select, active low
  input wire logic i_rd_n, // Read, active low
  input wire logic i_byte, // Byte select
  input wire logic i_cmp_above, // Comparator: input at or above trial
  output logic [SARPR_BITS-1:0] o_dac_trial, // Trial code to CDAC
  output logic o_hold, // Input held on array
  output logic o_sampling, // Acquisition in progress
  output logic o_busy, // Conversion in progress
  output logic [SARPR_BITS-1:0] o_output_data_pins, // Data out
  output logic o_output_data_oe, // Drive enable for data pins
  output logic o_result_trimmed // Latched result is past trim loads
);
  sarpr_state_e state_r;
  logic convert_start_n_prev_r;
  logic cs_prev_r;
  logic busy_r;
  logic [SARPR_BITS-1:0] sar_r;
  logic [SARPR_IDX_W-1:0] idx_r;
  logic [SARPR_STEP_W-1:0] step_cnt_r;
  logic done_r;
  logic [SARPR_TRIM_W-1:0] trim_cnt_r;
  sarpr_word_s latch_r;
  logic [SARPR_BITS-1:0] data_r;
  logic oe_r;
  logic hold_r;
  logic sampling_r;

  logic convert_start_n_fall;
  logic cs_fall;
  logic start;
  logic abort;
  logic step_en;
  logic push;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic busy_nxt;
  logic read_act;
  sarpr_word_s push_word;
  sarpr_word_s out_word;
  sarpr_state_e state_nxt;

  assign convert_start_n_fall = convert_start_n_prev_r & ~i_convert_start_n;
  assign cs_fall = cs_prev_r & ~i_cs_n;
  assign start = convert_start_n_fall & ~i_cs_n & ~busy_r;
  assign abort = busy_r & ((convert_start_n_fall & ~i_cs_n) | cs_fall);
  assign step_en = (state_r == ST_HOLD) & ~done_r &
    (step_cnt_r == SARPR_STEP_LAST);
  assign push = done_r & in_ready;
  assign read_act = ~i_cs_n & ~i_rd_n;
  // Hold off a latch update only in the first cycle of a read
  assign out_ready = ~(read_act & ~oe_r);
  assign push_word.trimmed = (trim_cnt_r == SARPR_TRIM_CONV);
  // Offset-binary search result to two's complement
  assign push_word.code = {~sar_r[SARPR_BITS-1], sar_r[SARPR_BITS-2:0]};

  always_comb
  begin
    if (abort)
      busy_nxt = 1'b0;
    else if (start)
      busy_nxt = 1'b1;
    else
      busy_nxt = (state_r == ST_HOLD) | out_valid;
  end

  sarpr_buf u_buf (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_flush(abort),
    .i_in_valid(done_r),
    .o_in_ready(in_ready),
    .i_in_data(push_word),
    .o_out_valid(out_valid),
    .i_out_ready(out_ready),
    .o_out_data(out_word)
  );

  // Edge history of host strobes
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      convert_start_n_prev_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      convert_start_n_prev_r <= i_convert_start_n;
      cs_prev_r <= i_cs_n;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      busy_r <= 1'b0;
    else
      busy_r <= busy_nxt;
  end

  // Sample / hold sequencing
  always_comb
  begin
    state_nxt = state_r;
    if (abort)
      state_nxt = ST_SAMPLE;
    else if (start)
      state_nxt = ST_HOLD;
    else
    begin
      unique case (state_r)
        ST_HOLD:
          if (push)
            state_nxt = ST_IDLE;
        ST_IDLE:
          if ((busy_r & ~busy_nxt & ~i_cs_n) | (cs_fall & ~busy_r))
            state_nxt = ST_SAMPLE;
        ST_SAMPLE:
          state_nxt = ST_SAMPLE;
      endcase
    end
  end

  // State and its decoded pins, all registered
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      hold_r <= 1'b0;
      sampling_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= (state_nxt == ST_HOLD);
      sampling_r <= (state_nxt == ST_SAMPLE);
    end
  end

  // Bit-step divider
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      step_cnt_r <= '0;
    else if (start | abort | step_en)
      step_cnt_r <= '0;
    else if (state_r == ST_HOLD)
      step_cnt_r <= step_cnt_r + 1'b1;
  end

  // Successive approximation, MSB first
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sar_r <= SARPR_SAR_INIT;
      idx_r <= SARPR_IDX_MSB;
      done_r <= 1'b0;
    end
    else if (start | abort)
    begin
      sar_r <= SARPR_SAR_INIT;
      idx_r <= SARPR_IDX_MSB;
      done_r <= 1'b0;
    end
    else if (push)
      done_r <= 1'b0;
    else if (step_en)
    begin
      if (!i_cmp_above)
        sar_r[idx_r] <= 1'b0;
      if (idx_r == SARPR_IDX_LSB)
        done_r <= 1'b1;
      else
      begin
        sar_r[idx_r - 1'b1] <= 1'b1;
        idx_r <= idx_r - 1'b1;
      end
    end
  end

  // Trim loads counted since power-up
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      trim_cnt_r <= '0;
    else if (push && trim_cnt_r != SARPR_TRIM_CONV)
      trim_cnt_r <= trim_cnt_r + 1'b1;
  end

  // Output latch
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      latch_r <= SARPR_WORD_ZERO;
    else if (abort)
      latch_r <= SARPR_WORD_ZERO;
    else if (out_valid & out_ready)
      latch_r <= out_word;
  end

  // Data pins follow byte-select and latch every cycle
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      data_r <= '0;
      oe_r <= 1'b0;
    end
    else
    begin
      oe_r <= read_act;
      if (i_byte)
        data_r <= {latch_r.code[SARPR_BYTE_W-1:0], SARPR_FILL_BYTE};
      else
        data_r <= latch_r.code;
    end
  end

  assign o_dac_trial = sar_r;
  assign o_hold = hold_r;
  assign o_sampling = sampling_r;
  assign o_busy = busy_r;
  assign o_output_data_pins = data_r;
  assign o_output_data_oe = oe_r;
  assign o_result_trimmed = latch_r.trimmed;
endmodule

// ==== sarpr_chk.sv ====
// Port assertions for the converter readout
`timescale 1ns/1ps
module sarpr_chk
  import sarpr_pkg::*;
(
  input wire logic i_clock, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_convert_start_n, // Start
  input wire logic i_cs_n, // Select
  input wire logic i_rd_n, // Read
  input wire logic i_byte, // Byte select
  input wire logic o_hold, // Hold
  input wire logic o_sampling, // Sampling
  input wire logic o_busy, // Busy
  input wire logic [SARPR_BITS-1:0] o_output_data_pins, // Data
  input wire logic o_output_data_oe // Drive enable
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_start;
    $fell(i_convert_start_n) && !i_cs_n && !o_busy |=> o_busy && o_hold;
  endproperty
  a_start: assert property (p_start)
    else $error("busy or hold missing after start");
  property p_oe;
    !$past(i_rst) |-> o_output_data_oe == $past(!i_cs_n && !i_rd_n);
  endproperty
  a_oe: assert property (p_oe)
    else $error("data drive enable wrong");
  property p_len;
    $rose(o_busy) |-> ##[1:37] !o_busy;
  endproperty
  a_len: assert property (p_len)
    else $error("conversion too long");
  property p_abort_start;
    o_busy && !i_cs_n && $fell(i_convert_start_n) |=> !o_busy;
  endproperty
  a_abort_start: assert property (p_abort_start)
    else $error("start during conversion did not reset");
  property p_abort_cs;
    o_busy && $fell(i_cs_n) |=> !o_busy && o_sampling;
  endproperty
  a_abort_cs: assert property (p_abort_cs)
    else $error("select during conversion did not reset");
  property p_zero;
    o_busy && $fell(i_cs_n) && !i_rd_n && !i_byte
      ##1 !i_cs_n && !i_rd_n && !i_byte |=> o_output_data_pins == 16'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("latches not cleared by reset");
  property p_fold;
    o_output_data_oe && $past(i_byte) |-> o_output_data_pins[7:0] == 8'hFF;
  endproperty
  a_fold: assert property (p_fold)
    else $error("lower pins not all ones");
  property p_samp;
    $fell(o_busy) && !i_cs_n |-> ##[0:1] o_sampling;
  endproperty
  a_samp: assert property (p_samp)
    else $error("sampling not restarted");
endmodule
bind sarpr_top sarpr_chk chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_convert_start_n(i_convert_start_n), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_byte(i_byte), .o_hold(o_hold), .o_sampling(o_sampling),
  .o_busy(o_busy), .o_output_data_pins(o_output_data_pins),
  .o_output_data_oe(o_output_data_oe));

// ==== sarpr_ana_model.sv ====
// Analog front-end stand-in answering the comparator
`timescale 1ns/1ps
module sarpr_ana_model
  import sarpr_pkg::*;
(
  input wire logic [SARPR_BITS-1:0] i_level, // Signed input
  input wire logic [SARPR_BITS-1:0] i_trial, // Trial code
  output logic o_above // Input at or above trial
);
  // Signed level seen as offset binary
  assign o_above =
    {~i_level[SARPR_BITS-1], i_level[SARPR_BITS-2:0]} >= i_trial;
endmodule

// ==== sarpr_tb_top.sv ====
// Self-checking bench for the converter readout
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sarpr_tb_top;
  import sarpr_pkg::*;
  logic i_clock = 0, i_rst = 1, st_n = 1, cs_n = 1, rd_n = 1, bsel = 0;
  logic cmp, busy, hold, samp, oe, trim;
  logic [15:0] ana = 16'h0, dac, pins;
  int n_fail = 0, comparisons = 0;
  sarpr_top dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_convert_start_n(st_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_byte(bsel),
    .i_cmp_above(cmp), .o_dac_trial(dac), .o_hold(hold),
    .o_sampling(samp), .o_busy(busy), .o_output_data_pins(pins),
    .o_output_data_oe(oe), .o_result_trimmed(trim));
  sarpr_ana_model ana_m (.i_level(ana), .i_trial(dac), .o_above(cmp));
  initial forever #10 i_clock = ~i_clock;
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic kick(); // Quiet bus, then a one-cycle start pulse
    rd_n = 1;
    cyc(3);
    st_n = 0;
    cyc(1);
    st_n = 1;
  endtask
  task automatic convert(logic [15:0] v);
    int k;
    logic [15:0] ob;
    ob = {~v[15], v[14:0]};
    ana = v;
    kick();
    `CHK("busy_up", 1'b1, busy)
    `CHK("hold_up", 1'b1, hold)
    k = 0;
    while (busy !== 1'b0 && k < 60)
    begin
      cyc(1);
      k++;
    end
    `CHK("busy_end", 1'b0, busy)
    `CHK("trial", ob, dac)
  endtask
  task automatic rd_chk(logic b, logic [15:0] e);
    rd_n = 0;
    bsel = b;
    cyc(2);
    `CHK("oe", 1'b1, oe)
    `CHK("pins", e, pins)
  endtask
  task automatic t_trim();
    cs_n = 0;
    cyc(2);
    `CHK("samp", 1'b1, samp)
    repeat (3)
    begin
      convert(16'h1234);
      `CHK("trim", 1'b0, trim)
    end
  endtask
  task automatic t_codes();
    logic [15:0] c[4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
    foreach (c[i])
    begin
      convert(c[i]);
      `CHK("trim", 1'b1, trim)
      rd_chk(0, c[i]);
      rd_chk(1, {c[i][7:0], 8'hFF});
      rd_chk(0, c[i]);
      rd_n = 1;
      cyc(2);
      `CHK("oe_off", 1'b0, oe)
    end
  endtask
  task automatic t_nocs();
    cs_n = 1;
    kick();
    `CHK("busy_nocs", 1'b0, busy)
    cs_n = 0;
    cyc(2);
  endtask
  task automatic t_abort_cs();
    kick();
    cs_n = 1;
    cyc(3);
    rd_n = 0;
    bsel = 0;
    cs_n = 0;
    cyc(1);
    `CHK("busy_abort", 1'b0, busy)
    `CHK("samp", 1'b1, samp)
    cyc(1);
    `CHK("zeroed", 16'h0, pins)
  endtask
  task automatic t_abort_start();
    convert(16'h0100);
    rd_chk(0, 16'h0100);
    kick();
    cyc(5);
    st_n = 0;
    cyc(1);
    `CHK("busy_abort", 1'b0, busy)
    st_n = 1;
    cyc(2);
    rd_chk(0, 16'h0);
  endtask
  initial
  begin
    repeat (12) @(negedge i_clock);
    i_rst = 0;
    t_trim();
    t_codes();
    t_nocs();
    t_abort_cs();
    t_abort_start();
    stop_test();
  end
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule
